// ---- src/dlc_pkg.sv ----
// dlc_pkg: constants and mode enumeration for the dual limit comparator
// assumes: included before the comparator and its edge detector
package dlc_pkg;

    // width of a signed reading and of each limit
    localparam int READING_WIDTH = 24;

    // measurement modes in the order the mode key steps through them
    typedef enum logic [1:0] {
        DLC_DIRECT_READOUT,
        DLC_DUAL_LIMITS,
        DLC_OFFSET_READOUT,
        DLC_TEMPERATURE
    } dlc_mode_e;

    // mode after reset
    localparam dlc_mode_e MODE_RESET = DLC_DIRECT_READOUT;

    // negated level of an active-low limit output
    localparam logic OUT_NEGATED = 1'b1;

    // outcome bits sit as {high, pass, low}; each bit is an active-low pin
    localparam int LOW_BIT  = 0;
    localparam int PASS_BIT = 1;
    localparam int HIGH_BIT = 2;

    // outcome codes; exactly one bit is low while a reading is classed
    localparam logic [2:0] CODE_IDLE  = {3{OUT_NEGATED}};
    localparam logic [2:0] CODE_BELOW = 3'h6;
    localparam logic [2:0] CODE_ABOVE = 3'h3;
    localparam logic [2:0] CODE_PASS  = 3'h5;

    // idle level of the remote reset pin and of its synchroniser
    localparam logic PIN_IDLE = 1'b1;

endpackage

// ---- src/dlc_fall_detect.sv ----
// dlc_fall_detect: two-stage synchroniser and falling-edge pulse
// assumes: asyncIn comes from a pin outside the clock domain
`timescale 1ns/1ns
module dlc_fall_detect (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic asyncIn,
    output logic      fallPulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    ////////////////////////////////////////////////////////////////////////
    // synchroniser then one delayed copy; idle level is high
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= dlc_pkg::PIN_IDLE;
            sync_q <= dlc_pkg::PIN_IDLE;
            prev_q <= dlc_pkg::PIN_IDLE;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // one pulse per high-to-low transition
    assign fallPulse = prev_q & ~sync_q;
endmodule

// ---- src/dlc_comparator.sv ----
// dlc_comparator: signed window comparison, limit outputs, mode step,
// remote reset key event
// assumes: reading and limits are on clk; remoteResetN is an async pin
`timescale 1ns/1ns
module dlc_comparator #(
    parameter int W = dlc_pkg::READING_WIDTH
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic signed [W-1:0] reading,
    input  wire logic                readingValid,
    input  wire logic signed [W-1:0] upperLimit,
    input  wire logic signed [W-1:0] lowerLimit,
    input  wire logic                modeKeyPress,
    input  wire logic                resetKeyPress,
    input  wire logic                remoteResetN,
    output logic [1:0]               modeSel,
    output logic                     resetKeyEvent,
    output logic                     limitLowN,
    output logic                     limitPassN,
    output logic                     limitHighN
);
    dlc_pkg::dlc_mode_e mode_q;
    dlc_pkg::dlc_mode_e mode_d;
    logic [2:0]         class_q;
    logic [2:0]         class_d;
    logic               remoteFall;
    logic               isBelow;
    logic               isAbove;
    logic               inDual;

    ////////////////////////////////////////////////////////////////////////
    // remote reset pin to one-cycle event
    dlc_fall_detect u_fall (
        .clk       (clk),
        .srst      (srst),
        .asyncIn   (remoteResetN),
        .fallPulse (remoteFall)
    );

    // remote event merges with the key, same action
    assign resetKeyEvent = resetKeyPress | remoteFall;

    ////////////////////////////////////////////////////////////////////////
    // mode key steps through the four modes in order
    always_comb begin
        case (mode_q)
            dlc_pkg::DLC_DIRECT_READOUT: mode_d = dlc_pkg::DLC_DUAL_LIMITS;
            dlc_pkg::DLC_DUAL_LIMITS:    mode_d = dlc_pkg::DLC_OFFSET_READOUT;
            dlc_pkg::DLC_OFFSET_READOUT: mode_d = dlc_pkg::DLC_TEMPERATURE;
            dlc_pkg::DLC_TEMPERATURE:    mode_d = dlc_pkg::DLC_DIRECT_READOUT;
            default:                     mode_d = dlc_pkg::MODE_RESET;
        endcase
    end

    // mode register; only a key press moves it
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q <= dlc_pkg::MODE_RESET;
        end else if (modeKeyPress) begin
            mode_q <= mode_d;
        end
    end

    // current mode out, and the one mode that drives the limit pins
    assign modeSel = mode_q;
    assign inDual  = (mode_q == dlc_pkg::DLC_DUAL_LIMITS);

    ////////////////////////////////////////////////////////////////////////
    // signed classification of the reading
    // all three operands are signed ports, so the compare stays signed
    assign isBelow = (reading < lowerLimit);
    assign isAbove = (reading > upperLimit);

    // outcome code for one reading: below first, then above, else pass;
    // below wins when the limits are set crossed
    function automatic logic [2:0] classCode(
        input logic below,
        input logic above
    );
        logic [2:0] code;
        if (below) begin
            code = dlc_pkg::CODE_BELOW; // only low asserted
        end else if (above) begin
            code = dlc_pkg::CODE_ABOVE; // only high asserted
        end else begin
            code = dlc_pkg::CODE_PASS; // only pass asserted
        end
        return code;
    endfunction

    // bits are {high, pass, low}, active low; below takes priority
    // a cycle with no reading keeps the previous answer standing
    always_comb begin
        if (!inDual) begin
            class_d = dlc_pkg::CODE_IDLE;
        end else if (!readingValid) begin
            class_d = class_q; // hold last classification
        end else begin
            class_d = classCode(isBelow, isAbove);
        end
    end

    // outcome register; the pins come straight from its bits
    always_ff @(posedge clk) begin
        if (srst) begin
            class_q <= dlc_pkg::CODE_IDLE;
        end else begin
            class_q <= class_d;
        end
    end

    // one active-low pin per outcome bit
    assign limitLowN  = class_q[dlc_pkg::LOW_BIT];
    assign limitPassN = class_q[dlc_pkg::PASS_BIT];
    assign limitHighN = class_q[dlc_pkg::HIGH_BIT];

    ////////////////////////////////////////////////////////////////////////
    // checks; a reading taken on an edge shows on the pins one edge later,
    // and a mode key press on that same edge does not change that answer
    chk_below_only_low: assert property (@(posedge clk) disable iff (srst)
        inDual && readingValid && isBelow
        |=> !limitLowN && limitPassN && limitHighN)
        else $error("below limit did not assert only low");

    chk_idle_all_high: assert property (@(posedge clk) disable iff (srst)
        !inDual |=> (limitLowN && limitPassN && limitHighN))
        else $error("outputs not high outside dual mode");

    chk_one_hot_low: assert property (@(posedge clk) disable iff (srst)
        inDual && $past(inDual) && $past(readingValid)
        |-> $countones({limitLowN, limitPassN, limitHighN}) == 2)
        else $error("not exactly one output asserted");

    chk_above_high: assert property (@(posedge clk) disable iff (srst)
        inDual && readingValid && !isBelow && isAbove && !modeKeyPress
        |=> !limitHighN && limitLowN)
        else $error("above limit not reported high");

    chk_pass_inside: assert property (@(posedge clk) disable iff (srst)
        inDual && readingValid && !isBelow && !isAbove && !modeKeyPress
        |=> !limitPassN)
        else $error("inside window not reported pass");

    chk_signed_cmp: assert property (@(posedge clk) disable iff (srst)
        inDual && readingValid && !modeKeyPress && reading[W-1]
        && !lowerLimit[W-1] |=> !limitLowN)
        else $error("negative reading not below positive lower limit");

    chk_hold_invalid: assert property (@(posedge clk) disable iff (srst)
        inDual && !readingValid && !modeKeyPress
        |=> $stable({limitLowN, limitPassN, limitHighN}))
        else $error("outputs changed with no new reading");

    chk_mode_step: assert property (@(posedge clk) disable iff (srst)
        modeKeyPress && mode_q == dlc_pkg::DLC_TEMPERATURE
        |=> mode_q == dlc_pkg::DLC_DIRECT_READOUT)
        else $error("mode did not wrap to direct readout");

    chk_remote_event: assert property (@(posedge clk) disable iff (srst)
        $fell(remoteResetN) |-> ##2 resetKeyEvent)
        else $error("remote reset low produced no key event");

    chk_single_pulse: assert property (@(posedge clk) disable iff (srst)
        remoteFall |=> !remoteFall)
        else $error("remote reset event longer than one cycle");

    ////////////////////////////////////////////////////////////////////////
    // checks of reset state, key path, held pin, mode steps and
    // signed limits below zero

    chk_reset_state: assert property (@(posedge clk) disable iff (srst)
        $past(srst) |-> limitLowN && limitPassN && limitHighN
        && modeSel == dlc_pkg::MODE_RESET)
        else $error("outputs or mode wrong after reset");

    chk_key_passes: assert property (@(posedge clk) disable iff (srst)
        resetKeyPress |-> resetKeyEvent)
        else $error("front key press produced no key event");

    chk_held_quiet: assert property (@(posedge clk) disable iff (srst)
        (!srst && !remoteResetN) [*4] |-> !remoteFall)
        else $error("held remote reset repeated the event");

    chk_mode_first: assert property (@(posedge clk) disable iff (srst)
        modeKeyPress && mode_q == dlc_pkg::DLC_DIRECT_READOUT
        |=> mode_q == dlc_pkg::DLC_DUAL_LIMITS)
        else $error("mode did not step from direct to dual limits");

    chk_mode_hold: assert property (@(posedge clk) disable iff (srst)
        !modeKeyPress |=> $stable(mode_q))
        else $error("mode changed with no key press");

    chk_leave_high: assert property (@(posedge clk) disable iff (srst)
        inDual && modeKeyPress
        |=> ##1 limitLowN && limitPassN && limitHighN)
        else $error("outputs not released after leaving dual mode");

    chk_low_clear: assert property (@(posedge clk) disable iff (srst)
        inDual && readingValid && !isBelow |=> limitLowN)
        else $error("low output asserted for a reading not below");

    chk_high_clear: assert property (@(posedge clk) disable iff (srst)
        inDual && readingValid && (isBelow || !isAbove)
        |=> limitHighN)
        else $error("high output asserted for a reading not above");

    chk_pass_clear: assert property (@(posedge clk) disable iff (srst)
        inDual && readingValid && (isBelow || isAbove)
        |=> limitPassN)
        else $error("pass output asserted outside the window");

    chk_signed_above: assert property (@(posedge clk) disable iff (srst)
        inDual && readingValid && !reading[W-1] && upperLimit[W-1]
        && lowerLimit[W-1] |=> !limitHighN)
        else $error("positive reading not above negative upper limit");
endmodule

// ---- tb/dlc_remote_src.sv ----
// dlc_remote_src: outside equipment that drives the remote reset pin
// assumes: pin has a pull-up, so it idles high while not pulled low
`timescale 1ns/1ns
module dlc_remote_src (
    input  wire logic holdLow,
    output logic      remoteResetN
);
    // pin moves out of step with the bench clock
    assign #2 remoteResetN = ~holdLow;
endmodule

// ---- tb/dlc_comparator_tb.sv ----
// dlc_comparator_tb: directed checks of limits, mode step and reset key
// assumes: package, design files and dlc_remote_src compiled first
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_fail++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module dlc_comparator_tb;
    logic               clk, srst, readingValid, modeKeyPress, holdLow;
    logic               resetKeyPress, remoteResetN, resetKeyEvent;
    logic signed [23:0] reading, upperLimit, lowerLimit;
    logic [1:0]         modeSel;
    logic               limitLowN, limitPassN, limitHighN;
    logic [7:0]         evCnt;
    int                 n_fail, comparisons, cyc;
    logic signed [23:0] rd [6] = '{-24'sh44C, -24'sh3E8, 24'sh3E8,
                                   24'sh3E9, -24'sh3E9, 24'sh0};
    logic [2:0]         ex [6] = '{3'h3, 3'h5, 3'h5, 3'h6, 3'h3, 3'h5};
    dlc_comparator u_dlc_comparator (.clk(clk), .srst(srst),
        .reading(reading), .readingValid(readingValid),
        .upperLimit(upperLimit), .lowerLimit(lowerLimit),
        .modeKeyPress(modeKeyPress), .resetKeyPress(resetKeyPress),
        .remoteResetN(remoteResetN), .modeSel(modeSel),
        .resetKeyEvent(resetKeyEvent), .limitLowN(limitLowN),
        .limitPassN(limitPassN), .limitHighN(limitHighN));
    dlc_remote_src u_dlc_remote_src (.holdLow(holdLow),
        .remoteResetN(remoteResetN));
    ////////////////////////////////////////////////////////////////////////
    // clock source
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // count reset key events and cut a hang short
    always @(posedge clk) begin
        evCnt <= srst ? 8'h00 : evCnt + 8'(resetKeyEvent);
        cyc++;
        if (cyc == 1000) begin
            n_fail++;
            final_report;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // drive helpers
    task automatic step(); @(posedge clk); #1; endtask
    task automatic pressMode();
        modeKeyPress = 1'b1;
        step();
        modeKeyPress = 1'b0;
        step();
    endtask
    task automatic chkOut(string nm, logic [2:0] e);
        `CHK(nm, e, {limitLowN, limitPassN, limitHighN})
    endtask
    task final_report;
        if (n_fail == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        {srst, readingValid, modeKeyPress, resetKeyPress, holdLow} = 5'h10;
        {reading, upperLimit, lowerLimit} = {24'sh0, 24'sh3E8, -24'sh3E8};
        {n_fail, comparisons, cyc} = '0;
        repeat (6) step();
        srst = 1'b0;
        chkOut("idle", 3'h7);
        for (int i = 1; i < 5; i++) begin
            pressMode();
            `CHK("mode", 2'(i), modeSel)
        end
        pressMode();
        chkOut("enter", 3'h7);
        // back-to-back readings around both limits
        for (int i = 0; i < 6; i++) begin
            reading = rd[i];
            readingValid = 1'b1;
            step();
            chkOut("limits", ex[i]);
        end
        // negative reading under a positive lower limit
        lowerLimit = 24'sh64;
        reading = -24'sh64;
        step();
        chkOut("neg_low", 3'h3);
        // window wholly below zero
        upperLimit = -24'sh3E8;
        lowerLimit = -24'sh7D0;
        reading = 24'sh64;
        step();
        chkOut("neg_high", 3'h6);
        reading = -24'sh5DC;
        step();
        chkOut("neg_pass", 3'h5);
        // no new reading: the last answer stands
        readingValid = 1'b0;
        reading = -24'sh44C;
        step();
        chkOut("hold", 3'h5);
        pressMode();
        step();
        chkOut("leave", 3'h7);
        reading = -24'sh44C;
        readingValid = 1'b1;
        step();
        readingValid = 1'b0;
        chkOut("ignored", 3'h7);
        resetKeyPress = 1'b1;
        #1 `CHK("key", 1'b1, resetKeyEvent)
        step();
        resetKeyPress = 1'b0;
        holdLow = 1'b1;
        repeat (10) step();
        `CHK("remote", 8'h02, evCnt)
        holdLow = 1'b0;
        repeat (4) step();
        holdLow = 1'b1;
        repeat (6) step();
        `CHK("again", 8'h03, evCnt)
        final_report;
    end
endmodule
